// File: hw/eeprom_ctl_pkg.sv
// constants, codes and states for the configuration memory access block
package eeprom_ctl_pkg;

    // register word offsets (byte addresses, word aligned)
    localparam logic [11:0] OFS_CTRL_WORD    = 12'h500;
    localparam logic [11:0] OFS_WORD_ADDRESS = 12'h504;
    localparam logic [11:0] OFS_DATA_WINDOW  = 12'h508;

    // command and state register, seen in word 0x500 lanes 2 and 3
    localparam int BIT_PERMIT  = 16;
    localparam int BIT_EMUL    = 21;
    localparam int BIT_BYTES   = 22;
    localparam int BIT_ALGO    = 23;
    localparam int CMD_LSB     = 24;
    localparam int CMD_MSB     = 26;
    localparam int BIT_CHKSUM  = 27;
    localparam int BIT_LOADING = 28;
    localparam int BIT_ACK_ERR = 29;
    localparam int BIT_WR_ERR  = 30;
    localparam int BIT_BUSY    = 31;
    localparam int LANE_CTRL_LO = 2;
    localparam int LANE_CTRL_HI = 3;
    localparam int DATA_WR_LANES = 2;

    localparam logic [2:0] CMD_IDLE   = 3'h0;
    localparam logic [2:0] CMD_READ   = 3'h1;
    localparam logic [2:0] CMD_WRITE  = 3'h2;
    localparam logic [2:0] CMD_RELOAD = 3'h4;

    localparam logic [31:0] RST_WORD_ADDRESS = 32'h00000000;
    localparam logic [31:0] RST_DATA_WINDOW  = 32'h00000000;
    localparam logic        RST_LOADING      = 1'h1;
    localparam logic [1:0]  STRAP_SETTLE     = 2'h2;
    localparam logic [1:0]  STRAP_DONE       = 2'h3;

    // serial memory addressing
    localparam logic [6:0]  DEV_ADDR_BASE = 7'h50;
    localparam logic [15:0] RELOAD_ADDR   = 16'h0000;

    // link timing: one quarter of a serial bit
    localparam int I2C_QUARTER_NS    = 625;
    localparam int LINK_PERIOD_PS    = 6000;
    localparam int QUARTER_CYC_INT   = (I2C_QUARTER_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC_INT - 1);

    // byte items of one transaction
    localparam logic [3:0] IT_DEVW    = 4'h0;
    localparam logic [3:0] IT_AHI     = 4'h1;
    localparam logic [3:0] IT_ALO     = 4'h2;
    localparam logic [3:0] IT_WD0     = 4'h3;
    localparam logic [3:0] IT_RESTART = 4'h3;
    localparam logic [3:0] IT_WD1     = 4'h4;
    localparam logic [3:0] IT_DEVR    = 4'h4;
    localparam logic [3:0] IT_RD0     = 4'h5;
    localparam logic [3:0] IT_RD3     = 4'h8;
    localparam logic [3:0] IT_STOP    = 4'h9;

    typedef enum logic {
        CS_IDLE = 1'b0,
        CS_RUN  = 1'b1
    } ctl_state_e;

    typedef enum logic [2:0] {
        LK_IDLE  = 3'b000,
        LK_START = 3'b001,
        LK_TX    = 3'b011,
        LK_RX    = 3'b010,
        LK_STOP  = 3'b110,
        LK_DONE  = 3'b111
    } link_state_e;

endpackage : eeprom_ctl_pkg

// File: hw/eeprom_access_ctl.sv
// configuration memory access control with serial link engine
// Summary of operation
// - command field write starts read, write, reload
// - command field self-clears when busy drops
// - idle or valid command clears write and acknowledge error flags
// - pending acknowledge error blocks command writes other than idle
// - algorithm flag selects one or two address bytes
// - algorithm flag taken from size strap
// - fetch size flag reads zero: four bytes
// - emulation flag stays zero, serial link used
// - network write permit gates write commands
// - write permit clears at frame start
// - host acknowledge while busy clears event bit
// - host may flag checksum, acknowledge errors while busy
// - network owns unless host control or access
// - word address register, both sides, resets zero
// - address and data writes only from owner
// - address and data writes blocked while busy
// - data upper half read-only, lower writable
// - multi-byte registers are little-endian
// - busy flag reads one during command
// - write without permit sets write error
// - missing acknowledge or bad code: command error
// - loading flag set until reload succeeds
`timescale 1ns/1ps
module eeprom_access_ctl
    import eeprom_ctl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    input  wire logic        net_wr,
    input  wire logic        net_rd,
    input  wire logic [11:0] net_addr,
    input  wire logic [3:0]  net_be,
    input  wire logic [31:0] net_wdata,
    output logic      [31:0] net_rdata,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [11:0] host_addr,
    input  wire logic [3:0]  host_be,
    input  wire logic [31:0] host_wdata,
    output logic      [31:0] host_rdata,
    input  wire logic        host_ctrl_cfg,
    input  wire logic        host_access_state,
    input  wire logic        frame_sof,
    input  wire logic        eeprom_size_strap,
    output logic             app_event_ack_clear,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    ctl_state_e   state;
    logic [2:0]   cmd_field;
    logic         ack_err;
    logic         wr_err;
    logic         loading;
    logic         chksum_err;
    logic         permit;
    logic         algo;
    logic [31:0]  word_addr;
    logic [31:0]  data_window;
    logic         strap_s1;
    logic         strap_s2;
    logic [1:0]   strap_wait;
    logic         req_tgl;
    logic         done_s1;
    logic         done_s2;
    logic         done_seen;
    logic         done_tgl;
    logic         nack;
    logic [31:0]  rd_shift;

    // ownership and register decode
    wire        net_owns   = !host_ctrl_cfg && !host_access_state;
    wire        busy       = (state == CS_RUN);
    wire        own_wr     = net_owns ? net_wr : host_wr;
    wire [11:0] own_addr   = net_owns ? net_addr : host_addr;
    wire [3:0]  own_be     = net_owns ? net_be : host_be;
    wire [31:0] own_wdata  = net_owns ? net_wdata : host_wdata;
    wire        own_wr_addr = own_wr && own_addr == OFS_WORD_ADDRESS && !busy;
    wire        own_wr_data = own_wr && own_addr == OFS_DATA_WINDOW && !busy;
    wire        own_cmd_wr = own_wr && own_addr == OFS_CTRL_WORD && own_be[LANE_CTRL_HI] && !busy;
    wire [2:0]  own_cmd    = own_wdata[CMD_MSB:CMD_LSB];
    wire        cmd_valid  = own_cmd == CMD_IDLE || own_cmd == CMD_READ
                             || own_cmd == CMD_WRITE || own_cmd == CMD_RELOAD;
    wire        cmd_take   = own_cmd_wr && (!ack_err || own_cmd == CMD_IDLE);
    wire        cmd_start  = cmd_take && (own_cmd == CMD_READ || own_cmd == CMD_RELOAD
                             || (own_cmd == CMD_WRITE && permit));
    wire        host_busy_wr = host_wr && host_addr == OFS_CTRL_WORD && host_be[LANE_CTRL_HI] && busy;
    wire        host_ack   = host_busy_wr && |(host_wdata[CMD_MSB:CMD_LSB] & cmd_field);
    wire        host_chk   = host_busy_wr && host_wdata[BIT_CHKSUM];
    wire        host_ackf  = host_busy_wr && host_wdata[BIT_ACK_ERR];
    wire        net_permit_wr = net_wr && net_addr == OFS_CTRL_WORD && net_be[LANE_CTRL_LO];
    wire        res_take   = done_s2 != done_seen;

    // emulation and fetch-size flags are constant zero
    wire [15:0] ctrl_bits  = {busy, wr_err, ack_err, loading, chksum_err, cmd_field,
                              algo, 1'b0, 1'b0, 4'h0, permit};
    wire [31:0] ctrl_word  = {ctrl_bits, 16'h0000};
    wire [31:0] net_rd_val = net_addr == OFS_CTRL_WORD ? ctrl_word
                           : net_addr == OFS_WORD_ADDRESS ? word_addr
                           : net_addr == OFS_DATA_WINDOW ? data_window : 32'h00000000;
    wire [31:0] host_rd_val = host_addr == OFS_CTRL_WORD ? ctrl_word
                            : host_addr == OFS_WORD_ADDRESS ? word_addr
                            : host_addr == OFS_DATA_WINDOW ? data_window : 32'h00000000;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            net_rdata  <= 32'h00000000;
            host_rdata <= 32'h00000000;
        end
        else
        begin
            if (net_rd)
                net_rdata <= net_rd_val;
            if (host_rd)
                host_rdata <= host_rd_val;
        end
    end

    // command sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state     <= CS_IDLE;
            cmd_field <= CMD_IDLE;
            req_tgl   <= 1'b0;
        end
        else
        begin
            case (state)
                CS_IDLE:
                begin
                    if (cmd_start)
                    begin
                        state     <= CS_RUN;
                        cmd_field <= own_cmd;
                        req_tgl   <= ~req_tgl;
                    end
                end
                CS_RUN:
                begin
                    if (res_take)
                    begin
                        state     <= CS_IDLE;
                        cmd_field <= CMD_IDLE;
                    end
                end
                default:
                begin
                    state     <= CS_IDLE;
                    cmd_field <= CMD_IDLE;
                end
            endcase
        end
    end

    // status flags: a set in the same cycle beats a clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_err    <= 1'b0;
            wr_err     <= 1'b0;
            loading    <= RST_LOADING;
            chksum_err <= 1'b0;
            permit     <= 1'b0;
            app_event_ack_clear <= 1'b0;
        end
        else
        begin
            if ((res_take && nack) || (cmd_take && !cmd_valid) || host_ackf)
                ack_err <= 1'b1;
            else if (cmd_take && cmd_valid)
                ack_err <= 1'b0;
            if (cmd_take && own_cmd == CMD_WRITE && !permit)
                wr_err <= 1'b1;
            else if (cmd_take && cmd_valid)
                wr_err <= 1'b0;
            if (cmd_start && own_cmd == CMD_RELOAD)
                loading <= 1'b1;
            else if (res_take && cmd_field == CMD_RELOAD)
                loading <= nack;
            if (host_chk)
                chksum_err <= 1'b1;
            else if (cmd_start && own_cmd == CMD_RELOAD)
                chksum_err <= 1'b0;
            // software write in the sof cycle wins; it belongs to the new frame
            if (net_permit_wr)
                permit <= net_wdata[BIT_PERMIT];
            else if (frame_sof)
                permit <= 1'b0;
            app_event_ack_clear <= host_ack;
        end
    end

    // size strap: synchronised, then caught once after reset release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_s1   <= 1'b0;
            strap_s2   <= 1'b0;
            strap_wait <= 2'h0;
            algo       <= 1'b0;
        end
        else
        begin
            strap_s1 <= eeprom_size_strap;
            strap_s2 <= strap_s1;
            if (strap_wait != STRAP_DONE)
                strap_wait <= strap_wait + 2'h1;
            if (strap_wait == STRAP_SETTLE)
                algo <= strap_s2;
        end
    end

    // byte lanes: lane k sits at offset + k
    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_lane
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    word_addr[8*k +: 8]   <= RST_WORD_ADDRESS[8*k +: 8];
                    data_window[8*k +: 8] <= RST_DATA_WINDOW[8*k +: 8];
                end
                else
                begin
                    if (own_wr_addr && own_be[k])
                        word_addr[8*k +: 8] <= own_wdata[8*k +: 8];
                    if (res_take && cmd_field == CMD_READ && !nack)
                        data_window[8*k +: 8] <= rd_shift[8*k +: 8];
                    else if (own_wr_data && own_be[k] && k < DATA_WR_LANES)
                        data_window[8*k +: 8] <= own_wdata[8*k +: 8];
                end
            end
        end
    endgenerate

    // completion crossing back from the link domain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_s1   <= 1'b0;
            done_s2   <= 1'b0;
            done_seen <= 1'b0;
        end
        else
        begin
            done_s1   <= done_tgl;
            done_s2   <= done_s1;
            done_seen <= done_s2;
        end
    end

    // link domain; operands below are held still by the busy state
    logic         lrst_s1;
    logic         lrst_s2;
    logic         req_s1;
    logic         req_s2;
    logic         req_seen;
    logic         sda_s1;
    logic         sda_s2;
    logic         scl_s1;
    logic         scl_s2;
    link_state_e  lstate;
    logic [1:0]   ph;
    logic [7:0]   qcnt;
    logic [3:0]   bitn;
    logic [3:0]   item;
    logic [7:0]   shreg;
    logic         next_sda_low;
    logic         next_scl_low;

    wire        op_write = cmd_field == CMD_WRITE;
    wire [15:0] eaddr    = cmd_field == CMD_RELOAD ? RELOAD_ADDR : word_addr[15:0];
    wire [15:0] baddr    = {eaddr[14:0], 1'b0};
    wire [7:0]  dev_w    = {DEV_ADDR_BASE[6:3], algo ? 3'h0 : baddr[10:8], 1'b0};
    wire        go       = req_s2 != req_seen;
    wire        stall    = ph == 2'h1 && !scl_s2 && lstate != LK_IDLE && lstate != LK_DONE;
    wire        tick     = qcnt == QUARTER_LAST && !stall;
    wire        bit_end  = tick && ph == 2'h3;
    wire [3:0]  item_nx  = (item == IT_DEVW && !algo) ? IT_ALO
                         : (op_write && item == IT_WD1) ? IT_STOP : item + 4'h1;
    // a repeated start is followed by the device read byte (dev_w with the read bit), not write data
    wire [3:0]  start_item = item == IT_RESTART ? IT_DEVR : item;

    function automatic logic [7:0] tx_of(input logic [3:0] it);
        case (it)
            IT_DEVW: tx_of = dev_w;
            IT_AHI:  tx_of = baddr[15:8];
            IT_ALO:  tx_of = baddr[7:0];
            IT_WD0:  tx_of = data_window[7:0];
            IT_WD1:  tx_of = op_write ? data_window[15:8] : (dev_w | 8'h01);
            default: tx_of = 8'hFF;
        endcase
    endfunction : tx_of

    always_comb
    begin
        next_scl_low = ph == 2'h0 || ph == 2'h3;
        next_sda_low = 1'b0;
        case (lstate)
            LK_START: next_sda_low = ph[1];
            LK_TX:    next_sda_low = bitn < 4'h8 && !shreg[7];
            LK_RX:    next_sda_low = bitn == 4'h8 && item != IT_RD3;
            LK_STOP:
            begin
                next_scl_low = ph == 2'h0;
                next_sda_low = ph != 2'h3;
            end
            default:  next_scl_low = 1'b0;
        endcase
    end

    always_ff @(posedge link_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lrst_s1 <= 1'b0;
            lrst_s2 <= 1'b0;
        end
        else
        begin
            lrst_s1 <= 1'b1;
            lrst_s2 <= lrst_s1;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_s2)
    begin
        if (!lrst_s2)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end
        else
        begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            sda_oe <= next_sda_low;
            scl_oe <= next_scl_low;
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    always_ff @(posedge link_clk or negedge lrst_s2)
    begin
        if (!lrst_s2)
        begin
            lstate   <= LK_IDLE;
            req_seen <= 1'b0;
            done_tgl <= 1'b0;
            nack     <= 1'b0;
            ph       <= 2'h0;
            qcnt     <= 8'h00;
            bitn     <= 4'h0;
            item     <= IT_DEVW;
            shreg    <= 8'hFF;
            rd_shift <= 32'h00000000;
        end
        else
        begin
            if (lstate != LK_IDLE && !stall)
                qcnt <= tick ? 8'h00 : qcnt + 8'h01;
            if (tick)
                ph <= ph + 2'h1;
            case (lstate)
                LK_IDLE:
                begin
                    if (go)
                    begin
                        req_seen <= req_s2;
                        nack     <= 1'b0;
                        item     <= IT_DEVW;
                        ph       <= 2'h0;
                        qcnt     <= 8'h00;
                        lstate   <= LK_START;
                    end
                end
                LK_START:
                begin
                    if (bit_end)
                    begin
                        lstate <= LK_TX;
                        bitn   <= 4'h0;
                        item   <= start_item;
                        shreg  <= tx_of(start_item);
                    end
                end
                LK_TX:
                begin
                    if (tick && ph == 2'h1 && bitn == 4'h8 && sda_s2)
                        nack <= 1'b1;
                    if (bit_end && bitn != 4'h8)
                    begin
                        bitn  <= bitn + 4'h1;
                        shreg <= {shreg[6:0], 1'b1};
                    end
                    else if (bit_end)
                    begin
                        bitn  <= 4'h0;
                        item  <= item_nx;
                        shreg <= tx_of(item_nx);
                        if (nack || item_nx == IT_STOP)
                            lstate <= LK_STOP;
                        else if (!op_write && item_nx == IT_RESTART)
                            lstate <= LK_START;
                        else if (!op_write && item_nx >= IT_RD0)
                            lstate <= LK_RX;
                    end
                end
                LK_RX:
                begin
                    if (tick && ph == 2'h1 && bitn != 4'h8)
                        shreg <= {shreg[6:0], sda_s2};
                    if (bit_end && bitn != 4'h8)
                        bitn <= bitn + 4'h1;
                    else if (bit_end)
                    begin
                        bitn     <= 4'h0;
                        rd_shift <= {shreg, rd_shift[31:8]};
                        item     <= item + 4'h1;
                        if (item == IT_RD3)
                            lstate <= LK_STOP;
                    end
                end
                LK_STOP:
                begin
                    if (bit_end)
                        lstate <= LK_DONE;
                end
                LK_DONE:
                begin
                    done_tgl <= ~done_tgl;
                    lstate   <= LK_IDLE;
                end
                default: lstate <= LK_IDLE;
            endcase
        end
    end

    sequence seq_own_cmd(logic [2:0] c);
        own_cmd_wr && own_cmd == c && !ack_err;
    endsequence

    AST_CMD_READ_START: assert property (@(posedge clk) disable iff (!rstn)
        seq_own_cmd(CMD_READ) |=> busy && cmd_field == CMD_READ)
        else $error("read command did not start");
    AST_CMD_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        $fell(busy) |-> cmd_field == CMD_IDLE)
        else $error("command field not cleared at end of busy");
    AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        own_cmd_wr && own_cmd == CMD_IDLE |=> !ack_err && !wr_err)
        else $error("idle code did not clear errors");
    AST_ERR_BLOCKS: assert property (@(posedge clk) disable iff (!rstn)
        ack_err && own_cmd_wr && own_cmd != CMD_IDLE |=> !busy && ack_err)
        else $error("command taken while acknowledge error pending");
    AST_ALGO_HELD: assert property (@(posedge clk) disable iff (!rstn)
        strap_wait == STRAP_DONE && $past(strap_wait) == STRAP_DONE |-> $stable(algo))
        else $error("algorithm flag moved after strap capture");
    AST_PERMIT_SOF: assert property (@(posedge clk) disable iff (!rstn)
        frame_sof && !net_permit_wr |=> !permit)
        else $error("write permit survived frame start");
    AST_NO_PERMIT_ERR: assert property (@(posedge clk) disable iff (!rstn)
        seq_own_cmd(CMD_WRITE) ##0 !permit |=> wr_err && !busy)
        else $error("write without permit not flagged");
    AST_BUSY_FREEZE: assert property (@(posedge clk) disable iff (!rstn)
        busy && !res_take |=> $stable(word_addr) && $stable(data_window))
        else $error("register changed while busy");
    AST_READ_FILL: assert property (@(posedge clk) disable iff (!rstn)
        res_take && cmd_field == CMD_READ && !nack |=> data_window == $past(rd_shift))
        else $error("read data not placed in data window");
    AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (!rstn)
        seq_own_cmd(CMD_READ) |=> busy [*8])
        else $error("busy dropped too early");

endmodule : eeprom_access_ctl

// File: bench/eeprom_model.sv
// serial configuration memory target, two address bytes
`timescale 1ns/1ps
module eeprom_model
(
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic mute,
    output logic      pull
);
    logic [7:0]  sh = 0;
    logic [3:0]  n = 0;
    logic [3:0]  k = 0;
    logic        rd = 0;
    logic [15:0] ptr = 0;
    logic [15:0] w = 0;
    wire  [7:0]  dat = ptr[7:0] ^ 8'hA5;
    initial pull = 0;
    always @(negedge sda)
        if (scl)
            {n, k, rd} = 0;
    always @(posedge scl)
    begin
        sh = {sh[6:0], sda};
        n = n + 4'h1;
    end
    // only touches the data line while the clock is low
    always @(negedge scl)
    begin
        if (n == 4'h8 && !rd)
        begin
            if (k == 4'h0)
                rd = sh[0];
            if (k == 4'h1)
                ptr[15:8] = sh;
            if (k == 4'h2)
                ptr[7:0] = sh;
            if (k == 4'h3)
                w[7:0] = sh;
            if (k == 4'h4)
                w[15:8] = sh;
            k = k + 4'h1;
            pull = !mute;
        end
        else if (n == 4'h8)
        begin
            ptr = ptr + 16'h1;
            pull = 0;
        end
        else if (n == 4'h9)
        begin
            n = 0;
            // a refused byte ends the burst so the stop can be seen
            rd = rd & !sh[0];
            pull = rd & !dat[7];
        end
        else
            pull = rd & !dat[7 - n];
    end
endmodule : eeprom_model

// File: bench/test_eeprom_access_ctl.sv
// self-checking bench for the configuration memory access block
`timescale 1ns/1ps
module test_eeprom_access_ctl;
    import eeprom_ctl_pkg::*;
    logic clk = 0, rstn = 0, link_clk = 0, net_wr = 0, net_rd = 0, host_wr = 0, host_rd = 0;
    logic host_ctrl_cfg = 0, host_access_state = 0, frame_sof = 0, mute = 0, pull, strap = 1;
    logic [11:0] net_addr = 0, host_addr = 0;
    logic [3:0] net_be = 0, host_be = 0;
    logic [31:0] net_wdata = 0, host_wdata = 0, net_rdata, host_rdata, rv, e, x = 95370;
    logic app_event_ack_clear, scl_o, scl_oe, sda_o, sda_oe, scl_i, sda_i;
    int num_errors = 0, comparisons = 0;
    assign scl_i = ~scl_oe;
    assign sda_i = ~(sda_oe | pull);
    initial forever #10 clk = ~clk;
    initial forever #3 link_clk = ~link_clk;
    eeprom_access_ctl eeprom_access_ctl_inst(.clk, .rstn, .link_clk, .net_wr, .net_rd, .net_addr, .net_be,
        .net_wdata, .net_rdata, .host_wr, .host_rd, .host_addr, .host_be, .host_wdata, .host_rdata,
        .host_ctrl_cfg, .host_access_state, .frame_sof, .eeprom_size_strap(strap), .app_event_ack_clear,
        .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
    eeprom_model eeprom_model_inst(.scl(scl_i), .sda(sda_i), .mute, .pull);
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : rnd
    function automatic logic [31:0] exp_rd(input logic [15:0] b);
        for (int k = 0; k < 4; k++)
            exp_rd[8*k +: 8] = 8'(b + k) ^ 8'hA5;
    endfunction : exp_rd
    task automatic acc(input logic h, input logic w, input logic [11:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        @(posedge clk) #1;
        if (h)
            {host_wr, host_rd, host_addr, host_be, host_wdata} = {w, !w, a, be, d};
        else
            {net_wr, net_rd, net_addr, net_be, net_wdata} = {w, !w, a, be, d};
        @(posedge clk) #1;
        {net_wr, net_rd, host_wr, host_rd} = 4'h0;
        rv = h ? host_rdata : net_rdata;
    endtask : acc
    task automatic chk(input logic [31:0] g, input logic [31:0] ex);
        comparisons++;
        if (g !== ex)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, ex);
        end
    endtask : chk
    task automatic cmd(input logic [2:0] c);
        acc(0, 1, OFS_CTRL_WORD, 4'h8, {5'h0, c, 24'h0});
        acc(0, 0, OFS_CTRL_WORD, 0, 0);
    endtask : cmd
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic idle();
        for (int j = 0; j < 20000; j++)
        begin
            acc(0, 0, OFS_CTRL_WORD, 0, 0);
            if (rv[BIT_BUSY] === 1'b0)
                return;
        end
        num_errors++;
        finish_test();
    endtask : idle
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rstn = 1;
        repeat (12) @(posedge clk);
        acc(0, 0, OFS_CTRL_WORD, 0, 0);
        chk(rv, 32'h1080_0000);
        chk({scl_o, sda_o}, 0);
        e = rnd();
        acc(0, 1, OFS_WORD_ADDRESS, 4'hF, e);
        acc(1, 1, OFS_WORD_ADDRESS, 4'hF, ~e);
        acc(1, 0, OFS_WORD_ADDRESS, 0, 0);
        chk(rv, e);
        host_ctrl_cfg = 1;
        acc(1, 1, OFS_WORD_ADDRESS, 4'h1, ~e);
        acc(1, 1, OFS_DATA_WINDOW, 4'hF, e);
        acc(0, 0, OFS_WORD_ADDRESS, 0, 0);
        chk(rv, {e[31:8], ~e[7:0]});
        acc(0, 0, OFS_DATA_WINDOW, 0, 0);
        chk(rv, {16'h0, e[15:0]});
        host_ctrl_cfg = 0;
        host_access_state = 1;
        acc(0, 1, OFS_WORD_ADDRESS, 4'hF, 0);
        acc(1, 0, OFS_WORD_ADDRESS, 0, 0);
        chk(rv, {e[31:8], ~e[7:0]});
        host_access_state = 0;
        cmd(CMD_WRITE);
        chk(rv & 32'hC700_0000, 32'h4000_0000);
        cmd(3'h3);
        chk(rv & 32'hA700_0000, 32'h2000_0000);
        cmd(CMD_READ);
        chk(rv & 32'hA700_0000, 32'h2000_0000);
        cmd(CMD_IDLE);
        chk(rv & 32'hE700_0000, 0);
        $display("register and error test done");
        e = rnd() & 32'h7FFF;
        acc(0, 1, OFS_WORD_ADDRESS, 4'hF, e);
        cmd(CMD_READ);
        chk(rv & 32'h8700_0000, 32'h8100_0000);
        acc(0, 1, OFS_WORD_ADDRESS, 4'hF, ~e);
        acc(1, 1, OFS_CTRL_WORD, 4'h8, 32'h0900_0000);
        chk({31'h0, app_event_ack_clear}, 1);
        idle();
        chk(rv & 32'hCF00_0000, 32'h0800_0000);
        acc(0, 0, OFS_WORD_ADDRESS, 0, 0);
        chk(rv, e);
        acc(0, 0, OFS_DATA_WINDOW, 0, 0);
        chk(rv, exp_rd(16'(e * 2)));
        acc(0, 1, OFS_CTRL_WORD, 4'h4, 32'h0001_0000);
        frame_sof = 1;
        @(posedge clk) #1 frame_sof = 0;
        acc(0, 0, OFS_CTRL_WORD, 0, 0);
        chk(rv & 32'h0001_0000, 0);
        acc(0, 1, OFS_CTRL_WORD, 4'h4, 32'h0001_0000);
        e = rnd();
        acc(0, 1, OFS_DATA_WINDOW, 4'h3, e);
        cmd(CMD_WRITE);
        chk(rv & 32'hE700_0000, 32'h8200_0000);
        idle();
        chk(rv & 32'h6000_0000, 0);
        chk({16'h0, eeprom_model_inst.w}, {16'h0, e[15:0]});
        cmd(CMD_RELOAD);
        idle();
        chk(rv & 32'h1000_0000, 0);
        mute = 1;
        cmd(CMD_READ);
        idle();
        chk(rv & 32'h2000_0000, 32'h2000_0000);
        $display("link test done");
        strap = 0;
        rstn = 0;
        repeat (6) @(posedge clk);
        #1 rstn = 1;
        repeat (12) @(posedge clk);
        acc(0, 0, OFS_CTRL_WORD, 0, 0);
        chk(rv, 32'h1000_0000);
        acc(0, 0, OFS_WORD_ADDRESS, 0, 0);
        chk(rv, 0);
        acc(0, 0, OFS_DATA_WINDOW, 0, 0);
        chk(rv, 0);
        $display("reset test done");
        finish_test();
    end
endmodule : test_eeprom_access_ctl
